// ===== core/adma_regs.svh
// Register offsets, field positions, reset values and fixed sizes of the
// converter-to-data-RAM sequencer. Included by every file that uses it.
`ifndef ADMA_REGS_SVH
`define ADMA_REGS_SVH

// Register offsets on the 8-bit register port
`define ADMA_OFS_CTRL      8'h00
`define ADMA_OFS_CFG       8'h01
`define ADMA_OFS_IPTR      8'h02
`define ADMA_OFS_IDATA     8'h03
`define ADMA_OFS_START_HI  8'h04
`define ADMA_OFS_START_LO  8'h05
`define ADMA_OFS_WPTR_HI   8'h06
`define ADMA_OFS_WPTR_LO   8'h07
`define ADMA_OFS_BOUND     8'h08
`define ADMA_OFS_STATUS    8'h09
`define ADMA_OFS_LIMIT_HI  8'h0A
`define ADMA_OFS_LIMIT_LO  8'h0B
`define ADMA_OFS_COUNT_HI  8'h0C
`define ADMA_OFS_COUNT_LO  8'h0D

// Control register fields
`define ADMA_CTRL_EN       7
`define ADMA_CTRL_DONE     6
`define ADMA_CTRL_MODE     5
`define ADMA_CTRL_ERR1     4
`define ADMA_CTRL_ERR0     3
`define ADMA_CTRL_WARN1    1
`define ADMA_CTRL_WARN0    0

// Configuration register fields
`define ADMA_CFG_HALT      7
`define ADMA_CFG_BUSY      6
`define ADMA_CFG_CNT_OVF   2
`define ADMA_CFG_EOO       0

// Instruction fields
`define ADMA_INS_CONT      7
`define ADMA_INS_DIFF      6
`define ADMA_INS_CONV1     5
`define ADMA_INS_CONV0     4

// Sizes and reset values
`define ADMA_INS_DEPTH     64
`define ADMA_ONCHIP_TOP    16'h1000
`define ADMA_RST_BYTE      8'h00
`define ADMA_RST_WORD      16'h0000
`endif

// ===== core/adma_pkg.sv
// Types shared by the sequencer top and its converter buffers.
// Assumes the register header is on the include path.
package adma_pkg;
  typedef logic [7:0]  adma_byte_t;
  typedef logic [15:0] adma_word_t;
  typedef logic [5:0]  adma_iaddr_t;

  // Gray codes along idle, fetch, decode, wait, write, next
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_FETCH  = 3'h1,
    ST_DECODE = 3'h3,
    ST_WAIT   = 3'h2,
    ST_WRITE  = 3'h6,
    ST_NEXT   = 3'h7
  } adma_state_t;
endpackage : adma_pkg

// ===== core/adma_buf_if.sv
// Connection between the sequencer and one converter result buffer.
// Assumes both ends share core_clk.
interface adma_buf_if;
  logic        done;
  logic [15:0] result;
  logic        take_en;
  logic        drain;
  logic        full;
  logic [15:0] word;
  logic        warn;
  logic        err;

  modport eng (output done, output result, output take_en, output drain,
               input full, input word, input warn, input err);
  modport cvt (input done, input result, input take_en, input drain,
               output full, output word, output warn, output err);
endinterface : adma_buf_if

// ===== core/adma_instr_mem.sv
// Instruction store: one write port and two registered read ports.
// Assumes all ports are on core_clk.
`include "adma_regs.svh"
module adma_instr_mem
  import adma_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Write port
  input  wire logic        wr_en,
  input  wire adma_iaddr_t wr_addr,
  input  wire adma_byte_t  wr_data,
  // Read ports
  input  wire adma_iaddr_t rd_addr_a,
  output adma_byte_t       rd_data_a,
  input  wire adma_iaddr_t rd_addr_b,
  output adma_byte_t       rd_data_b
);
  adma_byte_t mem_q [`ADMA_INS_DEPTH];

  always_ff @(posedge core_clk)
  begin
    if (wr_en)
      mem_q[wr_addr] <= wr_data;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data_a <= `ADMA_RST_BYTE;
      rd_data_b <= `ADMA_RST_BYTE;
    end
    else
    begin
      rd_data_a <= mem_q[rd_addr_a];
      rd_data_b <= mem_q[rd_addr_b];
    end
  end
endmodule // adma_instr_mem

// ===== core/adma_conv_buf.sv
// Result buffer of one converter path, one word plus one pending word, with warning and error.
// Assumes the done strobe is a one-cycle pulse on core_clk.
`include "adma_regs.svh"
module adma_conv_buf
  import adma_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // Sequencer side
  adma_buf_if.cvt   bus
);
  logic       full_q;
  adma_word_t buf_q;
  logic       pend_q;
  adma_word_t hold_q;
  logic       take;
  logic       move;

  // Result lands in the buffer at once when it is (or is becoming) empty
  assign take     = bus.done && bus.take_en && (!full_q || (bus.drain && !pend_q));
  assign move     = bus.drain && pend_q;
  assign bus.full = full_q;
  assign bus.word = buf_q;
  assign bus.warn = bus.done && bus.take_en && !take;
  assign bus.err  = bus.warn && pend_q && !move;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      full_q <= 1'b0;
      buf_q  <= `ADMA_RST_WORD;
      pend_q <= 1'b0;
      hold_q <= `ADMA_RST_WORD;
    end
    else if (!bus.take_en && !full_q)
      pend_q <= 1'b0;
    else
    begin
      if (take)
      begin
        buf_q  <= bus.result;
        full_q <= 1'b1;
      end
      else if (move)
        buf_q <= hold_q;
      else if (bus.drain)
        full_q <= 1'b0;
      if (bus.warn)
      begin
        hold_q <= bus.result;
        pend_q <= 1'b1;
      end
      else if (move)
        pend_q <= 1'b0;
    end
  end
endmodule // adma_conv_buf

// ===== core/adma_seq_top.sv
// Instruction-driven sequencer that moves converter results into data RAM.
// Assumes converter strobes and core RAM activity are on core_clk.
//
// Added by the designer: strobed register access and the register addresses.
`include "adma_regs.svh"

// Notes on behaviour
// - Sixty-four eight-bit instruction entries
// - Data port writes/reads entry at pointer
// - Pointer advances after each data port access
// - Engine only waits; never starts conversions
// - Zero byte ends; top bit adds continuous
// - Fetch converter 0, 1, or both in order
// - Differential from converter 0 overrides single-ended; code still fetches converter 1 if its bit is set
// - Two or four bytes per instruction
// - On-chip writes only when core idle
// - Halt clear gives engine external RAM
// - Core external accesses dropped while halt clear
// - External writes wait; overflow may lose data
// - Write pointer loads from start on enable
// - Write pointer advances by two or four
// - Status pointer loads from boundary at start
// - Mode 0 runs each instruction once
// - End instruction reloads status pointer
// - Mode 0 end: continuous or count down
// - Repeat counter loads limit at start
// - Mode 1 repeats instruction until count zero
// - Mode 1 end: continue or stop
// - Completion flag set when finished, software clears
// - Per-converter buffer with warning and error
// - Enable bit starts, stops, reads busy
module adma_seq_top
  import adma_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire adma_byte_t  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output adma_byte_t       reg_rdata,
  // Converter results
  input  wire logic        conv0_done,
  input  wire adma_word_t  conv0_word,
  input  wire logic        conv1_done,
  input  wire adma_word_t  conv1_word,
  // On-chip data RAM
  input  wire logic        core_onchip_busy,
  output logic             onchip_we,
  output adma_word_t       onchip_addr,
  output adma_byte_t       onchip_wdata,
  // External data RAM
  output logic             ext_we,
  output adma_word_t       ext_addr,
  output adma_byte_t       ext_wdata,
  output logic             ext_ram_halt,
  input  wire logic        core_ext_wr,
  input  wire logic        core_ext_rd,
  output logic             core_ext_wr_ok,
  output logic             core_ext_rd_ok
);
  // Instruction decoding used by fetch and by completion
  function automatic logic wants0(input adma_byte_t ins);
    return ins[`ADMA_INS_CONV0] | ins[`ADMA_INS_DIFF];
  endfunction

  function automatic logic wants1(input adma_byte_t ins);
    return ins[`ADMA_INS_CONV1];
  endfunction

  function automatic logic is_end(input adma_byte_t ins);
    return !wants0(ins) && !wants1(ins);
  endfunction

  adma_state_t state_q;
  adma_iaddr_t iptr_q;
  adma_iaddr_t bound_q;
  adma_iaddr_t status_q;
  adma_word_t  start_q;
  adma_word_t  wptr_q;
  adma_word_t  limit_q;
  adma_word_t  count_q;
  adma_byte_t  ins_q;
  logic        mode_q;
  logic        halt_q;
  logic        done_flag_q;
  logic        eoo_flag_q;
  logic        ovf_flag_q;
  logic [1:0]  warn_q;
  logic [1:0]  err_q;
  logic        sel1_q;
  logic        lo_byte_q;
  adma_word_t  byte_addr_q;
  adma_byte_t  byte_data_q;
  adma_byte_t  rdata_q;
  logic        rd_idata_q;

  adma_byte_t  ins_rd;
  adma_byte_t  sw_rd;
  adma_buf_if  cb0 ();
  adma_buf_if  cb1 ();

  // Register decode
  logic wr_ctrl;
  logic wr_cfg;
  logic idata_hit;
  logic start_cmd;
  logic stop_cmd;
  logic busy;
  assign wr_ctrl   = reg_wr && (reg_addr == `ADMA_OFS_CTRL);
  assign wr_cfg    = reg_wr && (reg_addr == `ADMA_OFS_CFG);
  assign idata_hit = (reg_wr || reg_rd) && (reg_addr == `ADMA_OFS_IDATA);
  assign busy      = (state_q != ST_IDLE);
  assign start_cmd = wr_ctrl && reg_wdata[`ADMA_CTRL_EN] && !busy;
  assign stop_cmd  = wr_ctrl && !reg_wdata[`ADMA_CTRL_EN];

  // Byte write grant: on-chip only when the core leaves it, off-chip by halt
  logic tgt_onchip;
  logic grant;
  logic writing;
  assign tgt_onchip = (byte_addr_q < `ADMA_ONCHIP_TOP);
  assign writing    = (state_q == ST_WRITE);
  assign grant      = tgt_onchip ? !core_onchip_busy : !halt_q;
  assign onchip_we    = writing && tgt_onchip && grant;
  assign onchip_addr  = byte_addr_q;
  assign onchip_wdata = byte_data_q;
  assign ext_we       = writing && !tgt_onchip && grant;
  assign ext_addr     = byte_addr_q;
  assign ext_wdata    = byte_data_q;
  assign ext_ram_halt = halt_q;

  // Core external accesses only reach RAM while it owns the bus
  assign core_ext_wr_ok = core_ext_wr && halt_q;
  assign core_ext_rd_ok = core_ext_rd && halt_q;

  // Converter buffers: collect only what the running instruction asks for
  logic       byte_done;
  logic       word_done;
  adma_word_t cur_word;
  logic       cur_full;
  assign cb0.done    = conv0_done;
  assign cb0.result  = conv0_word;
  assign cb0.take_en = busy && (state_q != ST_FETCH) && wants0(ins_q);
  assign cb1.done    = conv1_done;
  assign cb1.result  = conv1_word;
  assign cb1.take_en = busy && (state_q != ST_FETCH) && wants1(ins_q);
  assign byte_done   = writing && grant;
  assign word_done   = byte_done && lo_byte_q;
  assign cb0.drain   = word_done && !sel1_q;
  assign cb1.drain   = word_done && sel1_q;
  assign cur_word    = sel1_q ? cb1.word : cb0.word;
  assign cur_full    = sel1_q ? cb1.full : cb0.full;

  // Next instruction choice
  adma_word_t  count_dec;
  logic        ins_end;
  logic        cont;
  logic        second_word;
  assign count_dec   = count_q - 16'h0001;
  assign ins_end     = is_end(ins_q);
  assign cont        = ins_q[`ADMA_INS_CONT];
  assign second_word = !sel1_q && wants0(ins_q) && wants1(ins_q);

  adma_instr_mem u_mem (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .wr_en     (reg_wr && idata_hit),
    .wr_addr   (iptr_q),
    .wr_data   (reg_wdata),
    .rd_addr_a (iptr_q),
    .rd_data_a (sw_rd),
    .rd_addr_b (status_q),
    .rd_data_b (ins_rd)
  );

  adma_conv_buf u_buf0 (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .bus      (cb0.cvt)
  );

  adma_conv_buf u_buf1 (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .bus      (cb1.cvt)
  );

  // Software registers and sticky flags; a set in the clearing cycle wins
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      iptr_q  <= 6'h00;
      bound_q <= 6'h00;
      start_q <= `ADMA_RST_WORD;
      limit_q <= `ADMA_RST_WORD;
      mode_q  <= 1'b0;
      halt_q  <= 1'b0;
      warn_q  <= 2'h0;
      err_q   <= 2'h0;
    end
    else
    begin
      if (idata_hit)
        iptr_q <= iptr_q + 6'h01;
      else if (reg_wr && reg_addr == `ADMA_OFS_IPTR)
        iptr_q <= reg_wdata[5:0];
      if (reg_wr && reg_addr == `ADMA_OFS_BOUND)
        bound_q <= reg_wdata[5:0];
      if (reg_wr && reg_addr == `ADMA_OFS_START_HI)
        start_q[15:8] <= reg_wdata;
      if (reg_wr && reg_addr == `ADMA_OFS_START_LO)
        start_q[7:0] <= reg_wdata;
      if (reg_wr && reg_addr == `ADMA_OFS_LIMIT_HI)
        limit_q[15:8] <= reg_wdata;
      if (reg_wr && reg_addr == `ADMA_OFS_LIMIT_LO)
        limit_q[7:0] <= reg_wdata;
      if (wr_ctrl)
        mode_q <= reg_wdata[`ADMA_CTRL_MODE];
      if (wr_cfg)
        halt_q <= reg_wdata[`ADMA_CFG_HALT];
      warn_q <= (wr_ctrl ? (warn_q & {reg_wdata[`ADMA_CTRL_WARN1], reg_wdata[`ADMA_CTRL_WARN0]})
                         : warn_q) | {cb1.warn, cb0.warn};
      err_q  <= (wr_ctrl ? (err_q & {reg_wdata[`ADMA_CTRL_ERR1], reg_wdata[`ADMA_CTRL_ERR0]})
                         : err_q) | {cb1.err, cb0.err};
    end
  end

  // Sequencer
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q     <= ST_IDLE;
      status_q    <= 6'h00;
      wptr_q      <= `ADMA_RST_WORD;
      count_q     <= `ADMA_RST_WORD;
      ins_q       <= `ADMA_RST_BYTE;
      sel1_q      <= 1'b0;
      lo_byte_q   <= 1'b0;
      byte_addr_q <= `ADMA_RST_WORD;
      byte_data_q <= `ADMA_RST_BYTE;
      done_flag_q <= 1'b0;
      eoo_flag_q  <= 1'b0;
      ovf_flag_q  <= 1'b0;
    end
    else
    begin
      if (wr_ctrl && !reg_wdata[`ADMA_CTRL_DONE])
        done_flag_q <= 1'b0;
      if (wr_cfg && !reg_wdata[`ADMA_CFG_EOO])
        eoo_flag_q <= 1'b0;
      if (wr_cfg && !reg_wdata[`ADMA_CFG_CNT_OVF])
        ovf_flag_q <= 1'b0;
      if (stop_cmd)
      begin
        state_q <= ST_IDLE;
        ins_q   <= `ADMA_RST_BYTE;
      end
      else
      begin
        case (state_q)
          ST_IDLE:
          begin
            if (start_cmd)
            begin
              wptr_q   <= start_q;
              count_q  <= limit_q;
              status_q <= bound_q;
              state_q  <= ST_FETCH;
            end
          end
          ST_FETCH:
            state_q <= ST_DECODE;
          ST_DECODE:
          begin
            ins_q     <= ins_rd;
            sel1_q    <= !wants0(ins_rd);
            lo_byte_q <= 1'b0;
            state_q   <= is_end(ins_rd) ? ST_NEXT : ST_WAIT;
          end
          ST_WAIT:
          begin
            if (cur_full)
            begin
              byte_addr_q <= wptr_q;
              byte_data_q <= cur_word[15:8];
              state_q     <= ST_WRITE;
            end
          end
          ST_WRITE:
          begin
            if (byte_done)
            begin
              wptr_q    <= wptr_q + 16'h0001;
              lo_byte_q <= !lo_byte_q;
              if (!lo_byte_q)
              begin
                byte_addr_q <= byte_addr_q + 16'h0001;
                byte_data_q <= cur_word[7:0];
              end
              else if (second_word)
              begin
                sel1_q  <= 1'b1;
                state_q <= ST_WAIT;
              end
              else
                state_q <= ST_NEXT;
            end
          end
          ST_NEXT:
          begin
            state_q <= ST_FETCH;
            if (ins_end)
            begin
              eoo_flag_q <= 1'b1;
              status_q   <= bound_q;
              if (!cont && mode_q)
              begin
                state_q     <= ST_IDLE;
                done_flag_q <= 1'b1;
              end
              else if (!cont)
              begin
                count_q <= count_dec;
                if (count_dec == `ADMA_RST_WORD)
                begin
                  ovf_flag_q  <= 1'b1;
                  state_q     <= ST_IDLE;
                  done_flag_q <= 1'b1;
                end
              end
            end
            else if (!mode_q)
              status_q <= status_q + 6'h01;
            else if (count_dec == `ADMA_RST_WORD)
            begin
              count_q    <= limit_q;
              ovf_flag_q <= 1'b1;
              status_q   <= status_q + 6'h01;
            end
            else
              count_q <= count_dec;
          end
          default:
            state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // Register read-back, answered in the following cycle
  adma_byte_t rd_mux;
  assign rd_mux =
    (reg_addr == `ADMA_OFS_CTRL)     ? {busy, done_flag_q, mode_q, err_q, 1'b0, warn_q} :
    (reg_addr == `ADMA_OFS_CFG)      ? {halt_q, writing && !tgt_onchip, 3'h0,
                                        ovf_flag_q, 1'b0, eoo_flag_q} :
    (reg_addr == `ADMA_OFS_IPTR)     ? {2'h0, iptr_q} :
    (reg_addr == `ADMA_OFS_START_HI) ? start_q[15:8] :
    (reg_addr == `ADMA_OFS_START_LO) ? start_q[7:0] :
    (reg_addr == `ADMA_OFS_WPTR_HI)  ? wptr_q[15:8] :
    (reg_addr == `ADMA_OFS_WPTR_LO)  ? wptr_q[7:0] :
    (reg_addr == `ADMA_OFS_BOUND)    ? {2'h0, bound_q} :
    (reg_addr == `ADMA_OFS_STATUS)   ? {2'h0, status_q} :
    (reg_addr == `ADMA_OFS_LIMIT_HI) ? limit_q[15:8] :
    (reg_addr == `ADMA_OFS_LIMIT_LO) ? limit_q[7:0] :
    (reg_addr == `ADMA_OFS_COUNT_HI) ? count_q[15:8] :
    (reg_addr == `ADMA_OFS_COUNT_LO) ? count_q[7:0] : `ADMA_RST_BYTE;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q    <= `ADMA_RST_BYTE;
      rd_idata_q <= 1'b0;
    end
    else
    begin
      rdata_q    <= reg_rd ? rd_mux : `ADMA_RST_BYTE;
      rd_idata_q <= reg_rd && idata_hit;
    end
  end

  assign reg_rdata = rd_idata_q ? sw_rd : rdata_q;
endmodule // adma_seq_top

// ===== testbench/adma_far_model.sv
// Converter result registers and a flat data RAM facing the sequencer.
// Assumes the bench commands each converter result with a one-cycle go pulse.
module adma_far_model
  import adma_pkg::*;
(
  // Clock, reset and bench commands
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       go0,
  input  wire logic       go1,
  input  wire adma_word_t val0,
  input  wire adma_word_t val1,
  // Converter results
  output logic            conv0_done,
  output adma_word_t      conv0_word,
  output logic            conv1_done,
  output adma_word_t      conv1_word,
  // Data RAM write ports
  input  wire logic       onchip_we,
  input  wire adma_word_t onchip_addr,
  input  wire adma_byte_t onchip_wdata,
  input  wire logic       ext_we,
  input  wire adma_word_t ext_addr,
  input  wire adma_byte_t ext_wdata,
  output adma_word_t      wr_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  adma_byte_t mem [0:65535];
  // Results come only on the bench's go pulses; words are inverted between them
  assign conv0_done = go0;
  assign conv0_word = go0 ? val0 : ~val0;
  assign conv1_done = go1;
  assign conv1_word = go1 ? val1 : ~val1;
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      wr_cnt <= 16'h0000;
    else
      wr_cnt <= wr_cnt + 16'(onchip_we) + 16'(ext_we);
  always_ff @(posedge core_clk)
  begin
    if (onchip_we)
      mem[onchip_addr] <= onchip_wdata;
    if (ext_we)
      mem[ext_addr] <= ext_wdata;
  end
endmodule // adma_far_model

// ===== testbench/adma_seq_properties.sv
// Port-level checks of the sequencer top.
// Assumes one clock domain; bound to every sequencer top instance.
`include "adma_regs.svh"
module adma_seq_props
  import adma_pkg::*;
(
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire adma_byte_t reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire adma_byte_t reg_rdata,
  // Data RAM
  input wire logic       core_onchip_busy,
  input wire logic       onchip_we,
  input wire adma_word_t onchip_addr,
  input wire logic       ext_we,
  input wire adma_word_t ext_addr,
  input wire logic       ext_ram_halt,
  input wire logic       core_ext_wr,
  input wire logic       core_ext_rd,
  input wire logic       core_ext_wr_ok,
  input wire logic       core_ext_rd_ok
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  adma_word_t      last_q;
  wire             any_we  = onchip_we || ext_we;
  wire adma_word_t we_addr = onchip_we ? onchip_addr : ext_addr;
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      last_q <= 16'h0000;
    else if (any_we)
      last_q <= we_addr;
  sequence s_halt_wr;
    reg_wr && reg_addr == `ADMA_OFS_CFG;
  endsequence
  sequence s_no_read;
    !reg_rd;
  endsequence
  AST_ONCHIP_GRANT: assert property (onchip_we |-> !core_onchip_busy)
    else $error("on-chip write while core uses RAM");
  AST_EXT_GRANT: assert property (ext_we |-> !ext_ram_halt)
    else $error("external write while halted");
  AST_CORE_WR: assert property (core_ext_wr_ok == (core_ext_wr && ext_ram_halt))
    else $error("core external write pass wrong");
  AST_CORE_RD: assert property (core_ext_rd_ok == (core_ext_rd && ext_ram_halt))
    else $error("core external read pass wrong");
  AST_HALT_OWNER: assert property (s_halt_wr |=> ext_ram_halt == $past(reg_wdata[7]))
    else $error("halt bit not taken from write");
  AST_RDATA_IDLE: assert property (s_no_read |=> reg_rdata == 8'h00)
    else $error("read data outside read answer");
  AST_LOW_BYTE: assert property (any_we && we_addr[0] |-> we_addr == last_q + 16'h0001)
    else $error("low byte not after high byte");
  AST_RAM_SPLIT: assert property ((onchip_we |-> onchip_addr < 16'h1000) and (ext_we |-> ext_addr >= 16'h1000))
    else $error("write on wrong RAM port");
endmodule // adma_seq_props
bind adma_seq_top adma_seq_props adma_seq_props_inst (.core_clk(core_clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .core_onchip_busy(core_onchip_busy), .onchip_we(onchip_we),
  .onchip_addr(onchip_addr), .ext_we(ext_we), .ext_addr(ext_addr),
  .ext_ram_halt(ext_ram_halt), .core_ext_wr(core_ext_wr), .core_ext_rd(core_ext_rd),
  .core_ext_wr_ok(core_ext_wr_ok), .core_ext_rd_ok(core_ext_rd_ok));

// ===== testbench/tb.sv
// Register-level bench of the sequencer with converter and RAM model.
// Assumes the register map and instruction fields of the shared header.
`include "adma_regs.svh"
module tb
  import adma_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic       go0 = 1'b0, go1 = 1'b0, core_onchip_busy = 1'b0;
  logic       core_ext_wr = 1'b0, core_ext_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  adma_byte_t reg_wdata = 8'h00, reg_rdata, onchip_wdata, ext_wdata, d;
  adma_word_t val0 = 16'h0000, val1 = 16'h0000, ea, wr_cnt, onchip_addr, ext_addr;
  adma_word_t conv0_word, conv1_word, cyc = 16'h0000, n;
  logic       conv0_done, conv1_done, onchip_we, ext_we, ext_ram_halt;
  logic       core_ext_wr_ok, core_ext_rd_ok;
  int         fails = 0, samples_checked = 0, i, j;
  adma_byte_t prog [0:7] = '{8'h10, 8'h60, 8'h30, 8'h20, 8'h50, 8'h00, 8'h10, 8'h00};
  always #50 core_clk = ~core_clk;
  // Core traffic patterns competing for RAM
  always @(posedge core_clk)
  begin
    cyc <= cyc + 16'h0001;
    core_onchip_busy <= (cyc[1:0] == 2'h0);
    core_ext_wr <= cyc[0];
    core_ext_rd <= cyc[1];
  end
  adma_seq_top adma_seq_top_inst (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .conv0_done(conv0_done), .conv0_word(conv0_word), .conv1_done(conv1_done),
    .conv1_word(conv1_word), .core_onchip_busy(core_onchip_busy), .onchip_we(onchip_we),
    .onchip_addr(onchip_addr), .onchip_wdata(onchip_wdata), .ext_we(ext_we),
    .ext_addr(ext_addr), .ext_wdata(ext_wdata), .ext_ram_halt(ext_ram_halt),
    .core_ext_wr(core_ext_wr), .core_ext_rd(core_ext_rd),
    .core_ext_wr_ok(core_ext_wr_ok), .core_ext_rd_ok(core_ext_rd_ok));
  adma_far_model adma_far_model_inst (.core_clk(core_clk), .rst_n(rst_n), .go0(go0),
    .go1(go1), .val0(val0), .val1(val1), .conv0_done(conv0_done), .conv0_word(conv0_word),
    .conv1_done(conv1_done), .conv1_word(conv1_word), .onchip_we(onchip_we),
    .onchip_addr(onchip_addr), .onchip_wdata(onchip_wdata), .ext_we(ext_we),
    .ext_addr(ext_addr), .ext_wdata(ext_wdata), .wr_cnt(wr_cnt));
  task automatic finish_test();
    if (fails == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input adma_word_t got, input adma_word_t exp);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input adma_byte_t v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output adma_byte_t v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    v = reg_rdata;
  endtask
  task automatic chk_rd(input logic [7:0] a, input adma_byte_t exp);
    adma_byte_t v;
    rd(a, v);
    chk(16'(v), 16'(exp));
  endtask
  task automatic fire(input logic one, input adma_word_t v);
    @(posedge core_clk);
    if (one)
    begin
      go1 <= 1'b1;
      val1 <= v;
    end
    else
    begin
      go0 <= 1'b1;
      val0 <= v;
    end
    @(posedge core_clk);
    go0 <= 1'b0;
    go1 <= 1'b0;
  endtask
  task automatic word_chk(input adma_word_t v);
    chk(16'(adma_far_model_inst.mem[ea]), 16'(v[15:8]));
    chk(16'(adma_far_model_inst.mem[ea + 16'h0001]), 16'(v[7:0]));
    ea = ea + 16'h0002;
  endtask
  // Converter 1 answers first so the stored order cannot follow arrival order
  task automatic exec(input adma_byte_t ins, input adma_word_t v0, input adma_word_t v1);
    logic w0, w1;
    int   k;
    w0 = ins[4] | ins[6];
    w1 = ins[5];
    repeat (12) @(posedge core_clk);
    n = wr_cnt + 16'(2 * (int'(w0) + int'(w1)));
    if (w1)
      fire(1'b1, v1);
    if (w0)
      fire(1'b0, v0);
    for (k = 0; k < 200 && wr_cnt !== n; k++)
      @(posedge core_clk);
    chk(wr_cnt, n);
    if (w0)
      word_chk(v0);
    if (w1)
      word_chk(v1);
  endtask
  initial
  begin
    repeat (20000) @(posedge core_clk);
    fails++;
    finish_test();
  end
  initial
  begin
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    chk_rd(`ADMA_OFS_CTRL, 8'h00);
    chk_rd(8'h20, 8'h00);
    wr(`ADMA_OFS_IPTR, 8'h00);
    for (i = 0; i < 64; i++)
      wr(`ADMA_OFS_IDATA, 8'(i) ^ 8'hA5);
    chk_rd(`ADMA_OFS_IPTR, 8'h00);
    for (i = 0; i < 64; i++)
      chk_rd(`ADMA_OFS_IDATA, 8'(i) ^ 8'hA5);
    wr(`ADMA_OFS_IPTR, 8'h00);
    for (j = 0; j < 8; j++)
    begin
      if (j == 6)
        wr(`ADMA_OFS_IPTR, 8'h08);
      wr(`ADMA_OFS_IDATA, prog[j]);
    end
    wr(`ADMA_OFS_START_HI, 8'h01);
    wr(`ADMA_OFS_LIMIT_LO, 8'h02);
    ea = 16'h0100;
    wr(`ADMA_OFS_CTRL, 8'h80);
    for (i = 0; i < 2; i++)
      for (j = 0; j < 5; j++)
        exec(prog[j], 16'h1234 + 16'(j), 16'hC0DE - 16'(i));
    repeat (20) @(posedge core_clk);
    chk_rd(`ADMA_OFS_CTRL, 8'h40);
    chk_rd(`ADMA_OFS_CFG, 8'h05);
    chk_rd(`ADMA_OFS_WPTR_LO, 8'h1C);
    chk_rd(`ADMA_OFS_STATUS, 8'h00);
    chk_rd(`ADMA_OFS_COUNT_LO, 8'h00);
    wr(`ADMA_OFS_CTRL, 8'h00);
    wr(`ADMA_OFS_CFG, 8'h00);
    wr(`ADMA_OFS_START_HI, 8'h02);
    wr(`ADMA_OFS_BOUND, 8'h08);
    ea = 16'h0200;
    wr(`ADMA_OFS_CTRL, 8'hA0);
    exec(8'h10, 16'h5A01, 16'h0000);
    exec(8'h10, 16'h5A02, 16'h0000);
    repeat (20) @(posedge core_clk);
    chk_rd(`ADMA_OFS_CTRL, 8'h60);
    chk_rd(`ADMA_OFS_COUNT_LO, 8'h02);
    chk_rd(`ADMA_OFS_STATUS, 8'h08);
    chk_rd(`ADMA_OFS_WPTR_LO, 8'h04);
    wr(`ADMA_OFS_CTRL, 8'h00);
    wr(`ADMA_OFS_START_HI, 8'h30);
    rd(`ADMA_OFS_CFG, d);
    chk(16'(d[6]), 16'h0000);
    wr(`ADMA_OFS_CFG, 8'h80);
    wr(`ADMA_OFS_CTRL, 8'hA0);
    n = wr_cnt;
    for (i = 0; i < 3; i++)
    begin
      repeat (8) @(posedge core_clk);
      fire(1'b0, 16'h7700 + 16'(i));
    end
    repeat (8) @(posedge core_clk);
    chk(wr_cnt, n);
    chk_rd(`ADMA_OFS_CTRL, 8'hA9);
    chk_rd(`ADMA_OFS_CFG, 8'hC0);
    wr(`ADMA_OFS_CFG, 8'h00);
    n = n + 16'h0002;
    for (i = 0; i < 100 && wr_cnt !== n; i++)
      @(posedge core_clk);
    chk(wr_cnt, n);
    ea = 16'h3000;
    word_chk(16'h7700);
    wr(`ADMA_OFS_CTRL, 8'h00);
    rd(`ADMA_OFS_CTRL, d);
    chk(16'(d[7]), 16'h0000);
    finish_test();
  end
endmodule // tb
